// >>> rtl/snv_arr_if.sv
// Link between the command engine and the RAM and nonvolatile arrays.
`timescale 1ns/1ps
`include "snv_params.svh"
interface snv_arr_if;
  logic                       wr_en;
  logic [`SNV_ADDR_BITS-1:0]  wr_addr;
  logic [`SNV_DATA_BITS-1:0]  wr_data;
  logic [`SNV_ADDR_BITS-1:0]  rd_addr;
  logic [`SNV_DATA_BITS-1:0]  rd_data;
  logic                       save_go;
  logic                       restore_go;
  logic                       sleep_go;
  logic                       busy;
  logic                       busy_save;
  logic                       busy_restore;
  logic                       save_done;
  logic                       restore_done;
  logic                       por_active;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, save_go, restore_go, sleep_go,
                input rd_data, busy, busy_save, busy_restore, save_done, restore_done,
                por_active);
  modport arr  (input wr_en, wr_addr, wr_data, rd_addr, save_go, restore_go, sleep_go,
                output rd_data, busy, busy_save, busy_restore, save_done, restore_done,
                por_active);
endinterface // snv_arr_if

// >>> rtl/snv_array.sv
// RAM and nonvolatile arrays with timed save and restore, and a sleep that clears RAM at once.
`timescale 1ns/1ps
`include "snv_params.svh"
module snv_array #(
  parameter int unsigned SAVE_CYC = `SNV_SAVE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  snv_arr_if.arr    bus
);
  import snv_pkg::*;

  localparam logic [`SNV_TIMER_W-1:0] SAVE_LAST    = `SNV_TIMER_W'(SAVE_CYC - 1);
  localparam logic [`SNV_TIMER_W-1:0] RESTORE_LAST = `SNV_TIMER_W'(`SNV_RESTORE_CYC - 1);

  logic [`SNV_DATA_BITS-1:0] ram_ff [`SNV_WORDS];
  logic [`SNV_DATA_BITS-1:0] nv_ff  [`SNV_WORDS];
  snv_aop_t                  aop_ff;
  logic [`SNV_TIMER_W-1:0]   timer_ff;
  logic                      por_ff;
  logic                      last;

  // ==========================================================================
  // Transfer timing
  assign last             = (aop_ff == SNV_AOP_SAVE) ? (timer_ff == SAVE_LAST)
                                                     : (timer_ff == RESTORE_LAST);
  assign bus.busy         = (aop_ff != SNV_AOP_IDLE);
  assign bus.busy_save    = (aop_ff == SNV_AOP_SAVE);
  assign bus.busy_restore = (aop_ff == SNV_AOP_RESTORE);
  assign bus.save_done    = bus.busy_save && last;
  assign bus.restore_done = bus.busy_restore && last;
  assign bus.por_active   = por_ff;
  assign bus.rd_data      = ram_ff[bus.rd_addr];

  // The power-up restore starts straight out of reset.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aop_ff   <= SNV_AOP_RESTORE;
      timer_ff <= '0;
      por_ff   <= 1'b1;
    end else if (bus.busy) begin
      timer_ff <= last ? '0 : timer_ff + `SNV_TIMER_W'(1);
      if (last) begin
        aop_ff <= SNV_AOP_IDLE;
        por_ff <= 1'b0;
      end
    end else if (bus.restore_go) begin
      aop_ff <= SNV_AOP_RESTORE;
    end else if (bus.save_go) begin
      aop_ff <= SNV_AOP_SAVE;
    end
  end

  // ==========================================================================
  // Arrays
  // The copy lands at the end of the timed window, so a read during a
  // transfer still sees the old word.
  always_ff @(posedge ref_clk) begin
    if (bus.restore_done) begin
      ram_ff <= nv_ff;
    end else if (bus.sleep_go) begin
      for (int i = 0; i < `SNV_WORDS; i++) begin
        ram_ff[i] <= '0;
      end
    end else if (bus.wr_en) begin
      ram_ff[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `SNV_WORDS; i++) begin
        nv_ff[i] <= `SNV_NV_RESET;
      end
    end else if (bus.save_done) begin
      nv_ff <= ram_ff;
    end
  end
endmodule // snv_array

// >>> rtl/snv_params.svh
// Constants of the serial shadowed static RAM command interface.
`ifndef SNV_PARAMS_SVH
`define SNV_PARAMS_SVH
// ==========================================================================
// Clock and timing
`define SNV_CLK_PERIOD_NS   5
`define SNV_RESTORE_TIME_NS 2500
`define SNV_RESTORE_CYC     (`SNV_RESTORE_TIME_NS / `SNV_CLK_PERIOD_NS)
`define SNV_SAVE_TIME_MS    10
`define SNV_SAVE_CYC        ((`SNV_SAVE_TIME_MS * 1000000) / `SNV_CLK_PERIOD_NS)
`define SNV_TIMER_W         21
// ==========================================================================
// Instruction and data layout
`define SNV_INSTR_BITS      8
`define SNV_START_POS       7
`define SNV_ADDR_MSB        6
`define SNV_ADDR_LSB        3
`define SNV_OP_MSB          2
`define SNV_OP_LSB          0
`define SNV_INSTR_LAST      4'h7
`define SNV_DATA_LAST       4'hf
`define SNV_ADDR_BITS       4
`define SNV_DATA_BITS       16
`define SNV_WORDS           16
// ==========================================================================
// Reset values
`define SNV_NV_RESET        16'h0000
`define SNV_PIN_RESET       5'h18
`endif

// >>> rtl/snv_pkg.sv
// Types shared by the serial shadowed static RAM command interface.
package snv_pkg;
  // ==========================================================================
  // Serial engine states
  typedef enum logic [2:0] {
    SNV_IDLE  = 3'h0,
    SNV_INSTR = 3'h1,
    SNV_WDATA = 3'h3,
    SNV_DONE  = 3'h2,
    SNV_RDATA = 3'h5
  } snv_state_t;
  // ==========================================================================
  // Operation codes in the low three instruction bits
  typedef enum logic [2:0] {
    SNV_OP_CLR_WL  = 3'h0,
    SNV_OP_SAVE    = 3'h1,
    SNV_OP_SLEEP   = 3'h2,
    SNV_OP_WRITE   = 3'h3,
    SNV_OP_SET_WL  = 3'h4,
    SNV_OP_RESTORE = 3'h5,
    SNV_OP_READ0   = 3'h6,
    SNV_OP_READ1   = 3'h7
  } snv_opcode_t;
  // ==========================================================================
  // Array transfer in progress
  typedef enum logic [1:0] {
    SNV_AOP_IDLE    = 2'h0,
    SNV_AOP_RESTORE = 2'h1,
    SNV_AOP_SAVE    = 2'h3
  } snv_aop_t;
endpackage

// >>> rtl/snv_sync.sv
// Two-flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module snv_sync #(
  parameter int unsigned     W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic [W-1:0]  async_in,
  output logic [W-1:0]       sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff  <= RST;
      sync_out <= RST;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // snv_sync

// >>> rtl/snv_top.sv
// Serial command interface of a shadowed static RAM with nonvolatile backup.
// ==========================================================================
// Summary of operation
// - Eight-bit instruction shifted in, MSB first.
// - Chip select low clears instruction, enters standby.
// - Start bit, address bits 6..3, opcode 2..0.
// - Ignore input until a one starts instruction.
// - Stopped shift clock pauses shifting without loss.
// - Decode the seven operation codes.
// - Write latch gates writes and saves.
// - Write latch cleared at power-up.
// - Sleep loses RAM; only restore ends it.
// - Restore copies backup, sets previous-restore latch.
// - No writes or saves before a restore.
// - Save pin low requests a save.
// - Save needs request, write latch, restore latch.
// - Save blocks everything, then clears write latch.
// - Save completes within ten milliseconds.
// - Restore completes within 2.5 microseconds.
// - Write instruction followed by sixteen data bits.
// - Early deselect still writes bits received.
// - Bits beyond twenty-four overwrite earlier data.
// - Output floats except while read data drives.
// - Pins accepted only when no instruction executes.
// - First read bit on eighth falling edge.
// - Power-up restore ignores commands, sets no latch.
`timescale 1ns/1ps
`include "snv_params.svh"
module snv_top #(
  parameter int unsigned SAVE_CYC = `SNV_SAVE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic chip_select,
  input  wire logic serial_shift_clock,
  input  wire logic serial_in,
  input  wire logic save_n,
  input  wire logic restore_n,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      write_latch,
  output logic      prev_restore,
  output logic      sleep_mode,
  output logic      standby,
  output logic      save_busy,
  output logic      restore_busy
);
  import snv_pkg::*;

  localparam int RST_BOUND = `SNV_RESTORE_CYC;

  snv_arr_if bus ();

  logic [4:0]                pins_s;
  logic                      cs_s;
  logic                      sk_s;
  logic                      si_s;
  logic                      save_n_s;
  logic                      restore_n_s;
  logic                      sk_q_ff;
  logic                      cs_q_ff;
  logic                      sk_rise;
  logic                      sk_fall;
  logic                      cs_fall;
  logic                      busy;
  snv_state_t                state_ff;
  logic [`SNV_INSTR_BITS-1:0] instr_ff;
  logic [`SNV_INSTR_BITS-1:0] nxt_instr;
  logic [3:0]                bit_cnt_ff;
  snv_opcode_t               op;
  logic                      byte_done;
  logic                      is_rd;
  logic                      is_wr;
  logic [`SNV_ADDR_BITS-1:0] addr_ff;
  logic [`SNV_DATA_BITS-1:0] data_ff;
  logic                      wd_shift;
  logic                      wd_last;
  logic                      pend_ff;
  logic                      wr_ff;
  logic                      wr_allowed;
  logic                      oe_ff;
  logic                      out_ff;
  logic                      wl_ff;
  logic                      pr_ff;
  logic                      sleep_ff;
  logic                      standby_ff;
  logic                      pin_ok;
  logic                      restore_req;
  logic                      save_req;

  // ==========================================================================
  // Pin synchronisation and edge detection
  snv_sync #(
    .W   (5),
    .RST (`SNV_PIN_RESET)
  ) u_sync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in ({save_n, restore_n, serial_in, serial_shift_clock, chip_select}),
    .sync_out (pins_s)
  );

  assign cs_s        = pins_s[0];
  assign sk_s        = pins_s[1];
  assign si_s        = pins_s[2];
  assign restore_n_s = pins_s[3];
  assign save_n_s    = pins_s[4];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sk_q_ff <= 1'b0;
      cs_q_ff <= 1'b0;
    end else begin
      sk_q_ff <= sk_s;
      cs_q_ff <= cs_s;
    end
  end

  // Edges are taken from the shift clock itself, so any pause is harmless.
  assign sk_rise = sk_s && !sk_q_ff;
  assign sk_fall = !sk_s && sk_q_ff;
  assign cs_fall = cs_q_ff && !cs_s;
  assign busy    = bus.busy;

  // ==========================================================================
  // Instruction decode
  assign nxt_instr = {instr_ff[`SNV_INSTR_BITS-2:0], si_s};
  assign op        = snv_opcode_t'(nxt_instr[`SNV_OP_MSB:`SNV_OP_LSB]);
  assign is_rd     = (op == SNV_OP_READ0) || (op == SNV_OP_READ1);
  assign is_wr     = (op == SNV_OP_WRITE);
  assign byte_done = cs_s && !busy && sk_rise && (state_ff == SNV_INSTR) &&
                     (bit_cnt_ff == `SNV_INSTR_LAST);
  assign wd_shift  = cs_s && !busy && sk_rise && (state_ff == SNV_WDATA);
  assign wd_last   = wd_shift && (bit_cnt_ff == `SNV_DATA_LAST);

  // ==========================================================================
  // Serial engine
  // A save or the power-up restore holds the engine idle, so bits shifted
  // meanwhile are dropped rather than queued.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= SNV_IDLE;
      instr_ff   <= '0;
      bit_cnt_ff <= 4'h0;
    end else if (!cs_s || busy) begin
      state_ff   <= SNV_IDLE;
      instr_ff   <= '0;
      bit_cnt_ff <= 4'h0;
    end else if (sk_rise) begin
      case (state_ff)
        SNV_IDLE: begin
          if (si_s) begin
            instr_ff   <= 8'h01;
            bit_cnt_ff <= 4'h1;
            state_ff   <= SNV_INSTR;
          end
        end
        SNV_INSTR: begin
          instr_ff <= nxt_instr;
          if (bit_cnt_ff == `SNV_INSTR_LAST) begin
            bit_cnt_ff <= 4'h0;
            if (is_rd) begin
              state_ff <= SNV_RDATA;
            end else if (is_wr) begin
              state_ff <= SNV_WDATA;
            end else begin
              state_ff <= SNV_DONE;
            end
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        SNV_WDATA: begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
        SNV_RDATA: begin
          if (oe_ff) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == `SNV_DATA_LAST) begin
              state_ff <= SNV_DONE;
            end
          end
        end
        default: begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // ==========================================================================
  // Data word
  // The word is preloaded from RAM so that a cut-short write keeps the bits
  // that were never sent.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= '0;
      data_ff <= '0;
    end else if (byte_done && (is_rd || is_wr)) begin
      addr_ff <= instr_ff[`SNV_ADDR_MSB-1:`SNV_ADDR_LSB-1];
      data_ff <= bus.rd_data;
    end else if (wd_shift) begin
      data_ff[bit_cnt_ff] <= si_s;
    end
  end

  assign wr_allowed = wl_ff && pr_ff && !sleep_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'b0;
      wr_ff   <= 1'b0;
    end else begin
      wr_ff   <= wr_allowed && (wd_last || (cs_fall && pend_ff));
      pend_ff <= cs_s && !wd_last && (pend_ff || wd_shift);
    end
  end

  assign bus.wr_en   = wr_ff;
  assign bus.wr_addr = addr_ff;
  assign bus.wr_data = data_ff;
  assign bus.rd_addr = (state_ff == SNV_INSTR) ? instr_ff[`SNV_ADDR_MSB-1:`SNV_ADDR_LSB-1]
                                               : addr_ff;

  // ==========================================================================
  // Read output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oe_ff  <= 1'b0;
      out_ff <= 1'b0;
    end else if (!cs_s || busy || (state_ff != SNV_RDATA)) begin
      oe_ff <= 1'b0;
    end else if (sk_fall && !oe_ff) begin
      out_ff <= data_ff[0];
      oe_ff  <= 1'b1;
    end else if (sk_rise && oe_ff) begin
      if (bit_cnt_ff == `SNV_DATA_LAST) begin
        oe_ff <= 1'b0;
      end else begin
        out_ff <= data_ff[bit_cnt_ff + 4'h1];
      end
    end
  end

  assign serial_out    = out_ff;
  assign serial_out_oe = oe_ff;

  // ==========================================================================
  // Latches and power states
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wl_ff <= 1'b0;
    end else if (bus.save_done) begin
      wl_ff <= 1'b0;
    end else if (byte_done && (op == SNV_OP_SET_WL)) begin
      wl_ff <= 1'b1;
    end else if (byte_done && (op == SNV_OP_CLR_WL)) begin
      wl_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pr_ff    <= 1'b0;
      sleep_ff <= 1'b0;
    end else if (bus.restore_done && !bus.por_active) begin
      pr_ff    <= 1'b1;
      sleep_ff <= 1'b0;
    end else if (bus.sleep_go) begin
      pr_ff    <= 1'b0;
      sleep_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      standby_ff <= 1'b1;
    end else begin
      standby_ff <= !cs_s;
    end
  end

  // ==========================================================================
  // Transfer requests
  // Restore wins when both pins are low, since a save of unknown data is
  // the worse outcome.
  assign pin_ok      = !busy && (state_ff != SNV_WDATA) && (state_ff != SNV_RDATA);
  assign restore_req = (byte_done && (op == SNV_OP_RESTORE)) || (pin_ok && !restore_n_s);
  assign save_req    = (byte_done && (op == SNV_OP_SAVE)) || (pin_ok && !save_n_s);
  assign bus.restore_go = !busy && restore_req;
  assign bus.save_go    = !busy && !restore_req && save_req && wl_ff && pr_ff;
  assign bus.sleep_go   = byte_done && (op == SNV_OP_SLEEP);

  snv_array #(
    .SAVE_CYC (SAVE_CYC)
  ) u_array (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bus     (bus)
  );

  assign write_latch  = wl_ff;
  assign prev_restore = pr_ff;
  assign sleep_mode   = sleep_ff;
  assign standby      = standby_ff;
  assign save_busy    = bus.busy_save;
  assign restore_busy = bus.busy_restore;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  shift_in_a: assert property ((state_ff == SNV_INSTR) && sk_rise && cs_s && !busy &&
      (bit_cnt_ff != `SNV_INSTR_LAST) |=>
      (instr_ff == {$past(instr_ff[6:0]), $past(si_s)}))
    else $error("Instruction bit not shifted in MSB first.");
  // Standby is checked one edge on, since a reselect may lift it again right after.
  cs_clear_a: assert property (!cs_s |=> (state_ff == SNV_IDLE) && (instr_ff == 8'h00)
      && standby)
    else $error("Deselect did not clear the instruction or enter standby.");
  start_bit_a: assert property ((state_ff == SNV_IDLE) && sk_rise && !si_s |=>
      (state_ff == SNV_IDLE))
    else $error("Zero bit started an instruction.");
  static_hold_a: assert property (!sk_rise && cs_s && !busy && (state_ff == SNV_INSTR)
      |=> $stable(instr_ff))
    else $error("Instruction changed without a shift clock edge.");
  wl_clear_a: assert property (byte_done && (op == SNV_OP_CLR_WL) |=> !wl_ff)
    else $error("Clear-latch instruction left the write latch set.");
  write_gate_a: assert property (bus.wr_en |-> wl_ff && pr_ff && !sleep_ff)
    else $error("RAM write without both latches set.");
  save_gate_a: assert property (bus.save_go |-> wl_ff && pr_ff)
    else $error("Save started without both latches set.");
  save_end_a: assert property (bus.save_done |=> !wl_ff && !save_busy)
    else $error("Save end did not clear the write latch.");
  restore_time_a: assert property ($rose(restore_busy) |->
      ##[1:RST_BOUND] !restore_busy)
    else $error("Restore overran its time.");
  por_latch_a: assert property (bus.por_active && bus.restore_done |=> !pr_ff)
    else $error("Power-up restore set the previous-restore latch.");
  partial_wr_a: assert property (cs_fall && pend_ff && wr_allowed |=> bus.wr_en)
    else $error("Cut-short write was not committed.");
  oe_read_a: assert property (serial_out_oe |-> $past(state_ff == SNV_RDATA) && $past(cs_s))
    else $error("Output driven outside a read.");
  first_bit_a: assert property ($rose(serial_out_oe) |-> $past(sk_fall) &&
      (serial_out == $past(data_ff[0])))
    else $error("First read bit not on a falling edge.");
  pin_gate_a: assert property ((bus.restore_go || bus.save_go) && !byte_done |->
      (state_ff != SNV_WDATA) && (state_ff != SNV_RDATA))
    else $error("Pin transfer accepted during an instruction.");

  write_cov_c: cover property (bus.wr_en && wd_last == 1'b0);
  read_cov_c: cover property (serial_out_oe && sk_rise && (bit_cnt_ff == `SNV_DATA_LAST));
  save_cov_c: cover property (bus.save_done);
  sleep_cov_c: cover property (sleep_ff && bus.restore_done);
endmodule // snv_top

// >>> verif/snv_host_model.sv
// Host model that drives the serial pins and the save and restore pins.
`timescale 1ns/1ps
module snv_host_model (
  input  wire logic ref_clk,
  input  wire logic serial_out,
  output logic      chip_select,
  output logic      serial_shift_clock,
  output logic      serial_in,
  output logic      save_n,
  output logic      restore_n
);
  // Extra low-phase cycles, used to stop the shift clock in mid-frame.
  int stall = 0;
  initial begin
    {chip_select, serial_shift_clock, serial_in, save_n, restore_n} = 5'h03;
  end
  // ==========================================================================
  // Serial transfers
  // The data line is sampled at the end of the low phase, before the rise.
  task automatic bit_cyc(input logic d, output logic q);
    @(posedge ref_clk) serial_shift_clock <= 1'b0;
    serial_in <= d;
    repeat (6 + stall) @(posedge ref_clk);
    q = serial_out;
    serial_shift_clock <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [7:0] ins, input int lz, input int nd,
                       input logic [31:0] wd, output logic [15:0] rd);
    logic q;
    rd = 16'h0000;
    @(posedge ref_clk) chip_select <= 1'b1;
    for (int i = 0; i < lz; i++) bit_cyc(1'b0, q);
    for (int i = 7; i >= 0; i--) bit_cyc(ins[i], q);
    for (int i = 0; i < nd; i++) begin
      bit_cyc(wd[i], q);
      if (i < 16) rd[i] = q;
    end
    // The clock stands low and the line shows no stale value once deselected.
    @(posedge ref_clk) serial_shift_clock <= 1'b0;
    chip_select <= 1'b0;
    serial_in <= ~serial_in;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic pins(input logic s, input logic r);
    @(posedge ref_clk) save_n <= s;
    restore_n <= r;
    repeat (6) @(posedge ref_clk);
    save_n <= 1'b1;
    restore_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule // snv_host_model

// >>> verif/tb_snv_top.sv
// Self-checking bench for the serial shadowed static RAM command interface.
`timescale 1ns/1ps
module tb_snv_top;
  localparam int SAVE_CYC = 50;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        chip_select, serial_shift_clock, serial_in, save_n, restore_n;
  logic        serial_out, serial_out_oe, write_latch, prev_restore;
  logic        sleep_mode, standby, save_busy, restore_busy;
  logic [15:0] rd;
  int          err_count = 0;
  int          checked   = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  snv_top #(.SAVE_CYC(SAVE_CYC)) i_dut (.ref_clk, .resetn, .chip_select,
    .serial_shift_clock, .serial_in, .save_n, .restore_n, .serial_out, .serial_out_oe,
    .write_latch, .prev_restore, .sleep_mode, .standby, .save_busy, .restore_busy);
  snv_host_model i_host (.ref_clk, .serial_out, .chip_select, .serial_shift_clock,
    .serial_in, .save_n, .restore_n);
  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // A wait longer than the limit is itself a mismatch.
  task automatic idle_wait(input int lim);
    int n;
    n = 0;
    while ((save_busy !== 1'b0 || restore_busy !== 1'b0) && n <= lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk("busy_time", 16'h0000, {15'h0, n > lim});
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] ins);
    i_host.frame(ins, 0, 0, 32'h0, rd);
  endtask
  task automatic wr(input logic [3:0] a, input int nd, input logic [31:0] d);
    i_host.frame({1'b1, a, 3'h3}, 2, nd, d, rd);
  endtask
  task automatic rdw(input logic [3:0] a, input logic b0, input logic [15:0] exp);
    i_host.frame({1'b1, a, 2'h3, b0}, 0, 16, 32'h0, rd);
    chk("read_word", exp, rd);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    chk("write_latch", 16'h0, {15'h0, write_latch});
    chk("restore_busy", 16'h1, {15'h0, restore_busy});
    idle_wait(500);
    chk("prev_restore", 16'h0, {15'h0, prev_restore});
    cmd(8'h84);
    chk("write_latch", 16'h1, {15'h0, write_latch});
    wr(4'h5, 16, 32'h0000_beef);
    rdw(4'h5, 1'b0, 16'h0000);
    cmd(8'hfd);
    chk("restore_busy", 16'h1, {15'h0, restore_busy});
    idle_wait(500);
    chk("prev_restore", 16'h1, {15'h0, prev_restore});
    i_host.stall = 20;
    wr(4'h5, 16, 32'h0000_a5c3);
    i_host.stall = 0;
    rdw(4'h5, 1'b0, 16'ha5c3);
    chk("oe", 16'h0, {15'h0, serial_out_oe});
    chk("standby", 16'h1, {15'h0, standby});
    wr(4'h5, 4, 32'h0000_000a);
    rdw(4'h5, 1'b1, 16'ha5ca);
    wr(4'h3, 20, 32'h000f_1234);
    rdw(4'h3, 1'b0, 16'h123f);
    cmd(8'h80);
    chk("write_latch", 16'h0, {15'h0, write_latch});
    wr(4'h6, 16, 32'h0000_5555);
    rdw(4'h6, 1'b1, 16'h0000);
    i_host.pins(1'b0, 1'b1);
    chk("save_busy", 16'h0, {15'h0, save_busy});
    cmd(8'h84);
    cmd(8'h81);
    i_host.pins(1'b1, 1'b0);
    chk("save_busy", 16'h1, {15'h0, save_busy});
    chk("restore_busy", 16'h0, {15'h0, restore_busy});
    idle_wait(SAVE_CYC);
    chk("write_latch", 16'h0, {15'h0, write_latch});
    cmd(8'h82);
    chk("sleep", 16'h1, {15'h0, sleep_mode});
    rdw(4'h5, 1'b0, 16'h0000);
    i_host.pins(1'b1, 1'b0);
    chk("restore_busy", 16'h1, {15'h0, restore_busy});
    idle_wait(500);
    chk("sleep", 16'h0, {15'h0, sleep_mode});
    chk("prev_restore", 16'h1, {15'h0, prev_restore});
    rdw(4'h5, 1'b0, 16'ha5ca);
    rdw(4'h3, 1'b1, 16'h123f);
    cmd(8'h84);
    i_host.pins(1'b0, 1'b1);
    chk("save_busy", 16'h1, {15'h0, save_busy});
    idle_wait(SAVE_CYC);
    chk("write_latch", 16'h0, {15'h0, write_latch});
    end_of_test();
  end
  // Every test together needs a little over a tenth of this span.
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
endmodule // tb_snv_top
